// file: inc/autobaud_pkg.sv
// Package with constants and types for the auto-baud detection block.
package autobaud_pkg;
  localparam int COUNT_W        = 16;
  localparam int DIV_W          = 10;
  // Detection counter clock dividers per wide/high select combination.
  localparam logic [DIV_W-1:0] DET_DIV_WH  = 10'h020;
  localparam logic [DIV_W-1:0] DET_DIV_MID = 10'h080;
  localparam logic [DIV_W-1:0] DET_DIV_LL  = 10'h200;
  // Normal rate clock dividers per combination.
  localparam logic [DIV_W-1:0] RATE_DIV_WH  = 10'h004;
  localparam logic [DIV_W-1:0] RATE_DIV_MID = 10'h010;
  localparam logic [DIV_W-1:0] RATE_DIV_LL  = 10'h040;
  localparam logic [COUNT_W-1:0] COUNT_START = 16'h0001;
  localparam logic [2:0]         RISE_LAST   = 3'h5;
  localparam logic [7:0]         BYTE_RESET  = 8'h00;
  typedef enum logic [1:0] {ST_IDLE, ST_BREAK, ST_WAIT_START, ST_MEASURE} abd_state_t;
endpackage : autobaud_pkg

// file: logic/uart_auto_baud_detect.sv
// Auto-baud detection counter of an asynchronous serial receiver.
// What this block does
// - During detection both rate count bytes act as one 16-bit counter.
// - Detection tick is osc/32,128,128,512; rate tick osc/4,16,16,64 per selects.
// - Detection counter starts at a count of one.
// - With wake-on-break set, measure the character after the break.
// - Set overflow flag if the count passes 16 bits before fifth rise.
// - After overflow, keep counting until the fifth rising edge.
// - On fifth rising edge set receive flag and clear auto-baud enable.
// - Reading the receive buffer clears the receive flag.
// - Overflow flag stays set until software clears it directly.
`timescale 1ns/1ps
module uart_auto_baud_detect
  import autobaud_pkg::*;
(
  input  wire logic                               CLK_IN,
  input  wire logic                               RST_N_IN,
  input  wire logic                               RECEIVE_PIN_IN,
  input  wire logic                               WIDE_RATE_SELECT_IN,
  input  wire logic                               HIGH_RATE_SELECT_IN,
  input  wire logic                               WAKE_ON_BREAK_ENABLE_IN,
  input  wire logic                               AUTOBAUD_ENABLE_SET_IN,
  input  wire logic                               OVERFLOW_CLEAR_IN,
  input  wire logic                               RECEIVE_BUFFER_READ_IN,
  input  wire logic                               RATE_COUNT_WRITE_IN,
  input  wire logic [autobaud_pkg::COUNT_W-1:0]   RATE_COUNT_WRITE_DATA_IN,
  output logic                                    AUTOBAUD_ENABLE_OUT,
  output logic                                    AUTOBAUD_OVERFLOW_FLAG_OUT,
  output logic                                    RECEIVE_FLAG_OUT,
  output logic [7:0]                              RATE_COUNT_HIGH_OUT,
  output logic [7:0]                              RATE_COUNT_LOW_OUT,
  output logic                                    RATE_TICK_OUT
);
  import autobaud_pkg::*;

  // Detection state, measured count and enable.
  abd_state_t         state_reg,    state_next;
  logic [COUNT_W-1:0] count_reg,    count_next;
  logic [2:0]         rises_reg,    rises_next;
  logic               enable_reg,   enable_next;
  // Shared rate and detection divider.
  logic [DIV_W-1:0]   div_reg,      div_next;
  logic               tick_reg,     tick_next;
  // Receive pin edge detector.
  logic               rx_prev_reg,  rx_prev_next;
  // Software-visible flags.
  logic               ovf_reg,      ovf_next;
  logic               rxflag_reg,   rxflag_next;
  // Events passed from one group of state to another.
  logic [DIV_W-1:0]   div_limit;
  logic               rise;
  logic               fall;
  logic               div_done;
  logic               start_fall;
  logic               count_wrap;
  logic               fifth_rise;

  // The divider period follows the selects and whether detection runs.
  always_comb begin
    div_limit = DET_DIV_LL;
    case ({WIDE_RATE_SELECT_IN, HIGH_RATE_SELECT_IN})
      2'h3: div_limit = enable_reg ? DET_DIV_WH : RATE_DIV_WH;
      2'h2: div_limit = enable_reg ? DET_DIV_MID : RATE_DIV_MID;
      2'h1: div_limit = enable_reg ? DET_DIV_MID : RATE_DIV_MID;
      default: div_limit = enable_reg ? DET_DIV_LL : RATE_DIV_LL;
    endcase
  end

  // Edge detector; its reset level equals the idle line so no false edge follows reset.
  always_comb begin
    rx_prev_next = RECEIVE_PIN_IN;
    rise         = RECEIVE_PIN_IN & ~rx_prev_reg;
    fall         = ~RECEIVE_PIN_IN & rx_prev_reg;
  end

  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      rx_prev_reg <= 1'b1;
    end else begin
      rx_prev_reg <= rx_prev_next;
    end
  end

  // Divider: a limit that drops below the running count on a mode change
  // ends the period at once instead of letting the counter run round.
  always_comb begin
    div_done  = (div_reg >= div_limit - 10'h001);
    div_next  = div_done ? '0 : div_reg + 10'h001;
    tick_next = div_done & ~enable_reg;
    if (start_fall) begin
      div_next = '0;
    end
  end

  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      div_reg  <= '0;
      tick_reg <= 1'b0;
    end else begin
      div_reg  <= div_next;
      tick_reg <= tick_next;
    end
  end

  // Detection sequence and measured count.
  always_comb begin
    state_next  = state_reg;
    count_next  = count_reg;
    rises_next  = rises_reg;
    enable_next = enable_reg | AUTOBAUD_ENABLE_SET_IN;
    start_fall  = 1'b0;
    count_wrap  = 1'b0;
    fifth_rise  = 1'b0;
    if (RATE_COUNT_WRITE_IN && !enable_reg) begin
      count_next = RATE_COUNT_WRITE_DATA_IN;
    end
    case (state_reg)
      ST_IDLE: begin
        if (enable_reg) begin
          rises_next = '0;
          state_next = WAKE_ON_BREAK_ENABLE_IN ? ST_BREAK : ST_WAIT_START;
        end
      end
      ST_BREAK: begin
        // The break ends with the line returning high; the next fall starts the byte.
        if (rise) begin
          state_next = ST_WAIT_START;
        end
      end
      ST_WAIT_START: begin
        if (fall) begin
          start_fall = 1'b1;
          count_next = COUNT_START;
          state_next = ST_MEASURE;
        end
      end
      ST_MEASURE: begin
        if (div_done) begin
          // The count wraps to zero on overflow and keeps running.
          count_next = count_reg + 16'h0001;
          count_wrap = (count_reg == '1);
        end
        if (rise) begin
          rises_next = rises_reg + 3'h1;
          if (rises_reg + 3'h1 == RISE_LAST) begin
            fifth_rise  = 1'b1;
            count_next  = count_reg;
            enable_next = 1'b0;
            state_next  = ST_IDLE;
          end
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
    if (!enable_reg && state_reg != ST_IDLE) begin
      state_next = ST_IDLE;
    end
  end

  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      state_reg  <= ST_IDLE;
      count_reg  <= '0;
      rises_reg  <= '0;
      enable_reg <= 1'b0;
    end else begin
      state_reg  <= state_next;
      count_reg  <= count_next;
      rises_reg  <= rises_next;
      enable_reg <= enable_next;
    end
  end

  // Flags: a hardware set in the same cycle as a software clear wins.
  always_comb begin
    ovf_next    = ovf_reg & ~OVERFLOW_CLEAR_IN;
    rxflag_next = rxflag_reg & ~RECEIVE_BUFFER_READ_IN;
    if (count_wrap) begin
      ovf_next = 1'b1;
    end
    if (fifth_rise) begin
      rxflag_next = 1'b1;
    end
  end

  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      ovf_reg    <= 1'b0;
      rxflag_reg <= 1'b0;
    end else begin
      ovf_reg    <= ovf_next;
      rxflag_reg <= rxflag_next;
    end
  end

  // Every output is a register; the count bytes are the two halves of one counter.

  assign AUTOBAUD_ENABLE_OUT        = enable_reg;
  assign AUTOBAUD_OVERFLOW_FLAG_OUT = ovf_reg;
  assign RECEIVE_FLAG_OUT           = rxflag_reg;
  assign RATE_COUNT_HIGH_OUT        = count_reg[15:8];
  assign RATE_COUNT_LOW_OUT         = count_reg[7:0];
  assign RATE_TICK_OUT              = tick_reg;
endmodule : uart_auto_baud_detect

// file: bench/cal_char_source.sv
// Remote transmitter model sending a calibration character, with optional break.
`timescale 1ns/1ps
module cal_char_source (
  input  wire logic        clk_in, start_in, brk_in,
  input  wire logic [15:0] bit_in,
  output logic             line_out = 1'b1,
  output logic             busy_out = 1'b0
);
  int i;
  always @(posedge start_in) begin
    busy_out = 1'b1;
    if (brk_in) begin
      line_out = 1'b0;
      repeat (13 * bit_in) @(negedge clk_in);
      line_out = 1'b1;
      repeat (bit_in) @(negedge clk_in);
    end
    // Start, 8'h55 sent low bit first, stop: each level is bit 0 of the index.
    for (i = 0; i < 10; i++) begin
      line_out = i[0];
      repeat (bit_in) @(negedge clk_in);
    end
    busy_out = 1'b0;
  end
endmodule : cal_char_source

// file: bench/uart_auto_baud_detect_monitor.sv
// Port checker of the auto-baud detection block.
`timescale 1ns/1ps
module uart_auto_baud_detect_monitor (
  input wire logic CLK_IN, RST_N_IN, RATE_COUNT_WRITE_IN, RECEIVE_BUFFER_READ_IN,
  input wire logic OVERFLOW_CLEAR_IN, AUTOBAUD_ENABLE_OUT, AUTOBAUD_OVERFLOW_FLAG_OUT,
  input wire logic RECEIVE_FLAG_OUT, RATE_TICK_OUT,
  input wire logic [15:0] RATE_COUNT_WRITE_DATA_IN,
  input wire logic [7:0] RATE_COUNT_HIGH_OUT, RATE_COUNT_LOW_OUT);
  default clocking @(posedge CLK_IN); endclocking
  default disable iff (!RST_N_IN);
  wire logic en = AUTOBAUD_ENABLE_OUT;
  wire logic ovf = AUTOBAUD_OVERFLOW_FLAG_OUT;
  wire logic [15:0] cnt = {RATE_COUNT_HIGH_OUT, RATE_COUNT_LOW_OUT};
  property p_done; $fell(en) |-> RECEIVE_FLAG_OUT; endproperty
  a_done: assert property (p_done) else $error("end without flag");
  property p_rx_set; $rose(RECEIVE_FLAG_OUT) |-> $fell(en); endproperty
  a_rx_set: assert property (p_rx_set) else $error("stray flag");
  property p_rx_clr; RECEIVE_BUFFER_READ_IN && !en |=> !RECEIVE_FLAG_OUT; endproperty
  a_rx_clr: assert property (p_rx_clr) else $error("flag kept");
  property p_ovf_hold; ovf && !OVERFLOW_CLEAR_IN |=> ovf; endproperty
  a_ovf_hold: assert property (p_ovf_hold) else $error("overflow lost");
  property p_ovf_set; $rose(ovf) |-> $past(en); endproperty
  a_ovf_set: assert property (p_ovf_set) else $error("overflow idle");
  property p_step;
    en && $past(en) && $changed(cnt) |-> cnt == $past(cnt) + 16'h0001 || cnt == 16'h0001;
  endproperty
  a_step: assert property (p_step) else $error("bad count step");
  property p_tick; RATE_TICK_OUT |=> !RATE_TICK_OUT [*3]; endproperty
  a_tick: assert property (p_tick) else $error("tick too close");
  property p_quiet; en && $past(en) |-> !RATE_TICK_OUT; endproperty
  a_quiet: assert property (p_quiet) else $error("tick in detection");
  property p_wr; RATE_COUNT_WRITE_IN && !en |=> cnt == $past(RATE_COUNT_WRITE_DATA_IN); endproperty
  a_wr: assert property (p_wr) else $error("write lost");
  c_done: cover property ($fell(en));
  c_read: cover property (RECEIVE_BUFFER_READ_IN && RECEIVE_FLAG_OUT);
  c_refuse: cover property (RATE_COUNT_WRITE_IN && en);
endmodule : uart_auto_baud_detect_monitor
bind uart_auto_baud_detect uart_auto_baud_detect_monitor i_mon (.*);

// file: bench/uart_auto_baud_detect_tb.sv
// Self-checking testbench of the auto-baud detection block.
`timescale 1ns/1ps
module uart_auto_baud_detect_tb;
  import autobaud_pkg::*;
  logic CLK_IN = 0, RST_N_IN = 0, WIDE_RATE_SELECT_IN = 0, HIGH_RATE_SELECT_IN = 0, busy;
  logic WAKE_ON_BREAK_ENABLE_IN = 0, AUTOBAUD_ENABLE_SET_IN = 0, OVERFLOW_CLEAR_IN = 0;
  logic RECEIVE_BUFFER_READ_IN = 0, RATE_COUNT_WRITE_IN = 0, go = 0, brk = 0;
  logic RECEIVE_PIN_IN, AUTOBAUD_ENABLE_OUT, AUTOBAUD_OVERFLOW_FLAG_OUT, RECEIVE_FLAG_OUT;
  logic RATE_TICK_OUT;
  logic [15:0] RATE_COUNT_WRITE_DATA_IN = 16'h0000, bit_c = 16'h0020;
  logic [7:0] RATE_COUNT_HIGH_OUT, RATE_COUNT_LOW_OUT;
  logic [9:0] dd;
  int failures = 0, total_checks = 0, seed = 32'h06CA, cyc = 0, n;
  uart_auto_baud_detect i_dut (.*);
  cal_char_source i_src (.clk_in(CLK_IN), .start_in(go), .brk_in(brk), .bit_in(bit_c),
    .line_out(RECEIVE_PIN_IN), .busy_out(busy));
  always #25 CLK_IN = ~CLK_IN;
  always @(posedge CLK_IN) if (++cyc == 90000) begin failures++; end_sim(); end
  function logic [9:0] div_of(input logic w, h, det);
    return det ? (w & h ? DET_DIV_WH : w | h ? DET_DIV_MID : DET_DIV_LL)
               : (w & h ? RATE_DIV_WH : w | h ? RATE_DIV_MID : RATE_DIV_LL);
  endfunction : div_of
  task chk(input string nm, input logic [15:0] exp, got, input int tol);
    total_checks++;
    if (!((16'(got - exp + tol) <= 2 * tol) === 1'b1)) begin
      failures++;
      $display("FAIL %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task end_sim;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : end_sim
  initial begin
    repeat (4) @(negedge CLK_IN);
    RST_N_IN = 1;
    for (int k = 0; k < 5; k++) begin
      brk = k == 4;
      {WAKE_ON_BREAK_ENABLE_IN, OVERFLOW_CLEAR_IN, AUTOBAUD_ENABLE_SET_IN} = {brk, 2'b11};
      @(negedge CLK_IN);
      {OVERFLOW_CLEAR_IN, AUTOBAUD_ENABLE_SET_IN} = 2'b00;
      {WIDE_RATE_SELECT_IN, HIGH_RATE_SELECT_IN} = brk ? 2'b11 : 2'(k);
      dd = div_of(WIDE_RATE_SELECT_IN, HIGH_RATE_SELECT_IN, 1'b1);
      bit_c = 16'(dd * (2 + $unsigned($random(seed)) % 4));
      repeat (2) @(negedge CLK_IN);
      {go, RATE_COUNT_WRITE_IN, RATE_COUNT_WRITE_DATA_IN} = {2'b11, 16'($random(seed))};
      @(negedge CLK_IN);
      {go, RATE_COUNT_WRITE_IN} = 2'b00;
      for (n = 0; AUTOBAUD_ENABLE_OUT === 1 && n < 30000; n++) @(negedge CLK_IN);
      chk("receive flag", 1, RECEIVE_FLAG_OUT, 0);
      chk("enable", 0, AUTOBAUD_ENABLE_OUT, 0);
      chk("overflow", 0, AUTOBAUD_OVERFLOW_FLAG_OUT, 0);
      chk("count", 1 + 9 * bit_c / dd, {RATE_COUNT_HIGH_OUT, RATE_COUNT_LOW_OUT}, 1);
      RECEIVE_BUFFER_READ_IN = 1;
      @(negedge CLK_IN);
      RECEIVE_BUFFER_READ_IN = 0;
      chk("receive clear", 0, RECEIVE_FLAG_OUT, 0);
      for (n = 0; RATE_TICK_OUT !== 1 && n < 600; n++) @(negedge CLK_IN);
      n = 0;
      do begin @(negedge CLK_IN); n++; end while (RATE_TICK_OUT !== 1 && n < 600);
      chk("tick gap", div_of(WIDE_RATE_SELECT_IN, HIGH_RATE_SELECT_IN, 1'b0), 16'(n), 0);
      {RATE_COUNT_WRITE_IN, RATE_COUNT_WRITE_DATA_IN} = {1'b1, 16'($random(seed))};
      @(negedge CLK_IN);
      RATE_COUNT_WRITE_IN = 0;
      chk("rate write", RATE_COUNT_WRITE_DATA_IN, {RATE_COUNT_HIGH_OUT, RATE_COUNT_LOW_OUT}, 0);
      wait (busy === 1'b0);
    end
    end_sim();
  end
endmodule : uart_auto_baud_detect_tb
